// File: core/smsp_core.sv
// Strobed register access was chosen for this implementation.
`timescale 1ns/10ps
module smsp_core #(
	parameter int EDGES = 16 // Serial clock edges per byte.
) (
	input wire logic clk, // System clock, 100 MHz.
	input wire logic rst, // Synchronous reset, active high.
	input wire logic [7:0] addr, // Register address.
	input wire logic [7:0] wdata, // Register write data.
	input wire logic wrEn, // Write strobe.
	input wire logic rdEn, // Read strobe.
	output logic [7:0] rdata, // Read data, cycle after the strobe.
	input wire logic sclkIn, // Serial clock pin level.
	output logic sclkOut, // Serial clock drive value.
	output logic sclkOe, // Serial clock drive enable.
	input wire logic mosiIn, // Master-out line level.
	output logic mosiOut, // Master-out drive value.
	output logic mosiOe, // Master-out drive enable.
	input wire logic misoIn, // Master-in line level.
	output logic misoOut, // Master-in drive value.
	output logic misoOe, // Master-in drive enable.
	input wire logic ssIn, // Slave-select pin level, low selects.
	output logic ssOut, // Slave-select drive value.
	output logic select_output_enable, // Slave-select drive enable.
	output logic irqReq // Serial interrupt request.
);
	import smsp_pkg::*;

	////////////////////////////////////////////////////////////////////
	// Helpers.

	// Shift one bit into the byte in the configured direction.
	function automatic logic [7:0] shiftIn(input logic [7:0] v,
		input logic b, input logic lsb);
		shiftIn = lsb ? {b, v[7:1]} : {v[6:0], b};
	endfunction

	// The bit that goes out next.
	function automatic logic pick(input logic [7:0] v, input logic lsb);
		pick = lsb ? v[0] : v[7];
	endfunction

	// Half-period limit of the master divider.
	function automatic logic [2:0] divLimit(input logic [1:0] sel);
		case (sel)
			2'b00: divLimit = HALF_DIV2;
			2'b01: divLimit = HALF_DIV4;
			2'b10: divLimit = HALF_DIV8;
			default: divLimit = HALF_DIV16;
		endcase
	endfunction

	// Fill the bits not yet received with ones.
	function automatic logic [7:0] fillOnes(input logic [7:0] v,
		input logic [2:0] got, input logic lsb);
		logic [7:0] r;
		r = v;
		for (int i = 0; i < 8; i++) begin
			if (i >= int'(got)) begin
				r = shiftIn(r, 1'b1, lsb);
			end
		end
		fillOnes = r;
	endfunction

	////////////////////////////////////////////////////////////////////
	// State.

	logic [7:0] ctrl_ff; // Control register.
	logic [1:0] irqEn_ff; // Serial and global interrupt enables.
	logic done_ff; // Transfer done flag.
	logic write_collision_flag_ff; // Write collision flag.
	logic ovf_ff; // Overrun flag.
	logic mode_fault_flag_ff; // Mode fault flag.
	logic noFault_ff; // Fault detection disable.
	logic txFull_ff; // Shifter holds unsent data.
	logic [7:0] sh_ff; // Shift register.
	logic [7:0] rxBuf_ff; // Read data buffer.
	logic rxBit_ff; // Bit sampled, waiting for the shift edge.
	logic outBit_ff; // Bit presented on the data line.
	logic [3:0] edgeCnt_ff; // Serial clock edges seen in this byte.
	logic [2:0] divCnt_ff; // Master divider count.
	logic sclk_ff; // Master serial clock level.
	logic sclkPrev_ff; // Previous sampled clock pin level.
	logic ssPrev_ff; // Previous sampled select pin level.
	logic [7:0] rdata_ff; // Read data.
	logic irq_ff; // Interrupt request.
	logic ssOut_ff; // Select drive value.
	logic select_output_enable_ff; // Select drive enable.
	logic sclkOe_ff; // Clock drive enable.
	logic mosiOe_ff; // Master-out drive enable.
	logic misoOe_ff; // Master-in drive enable.
	smsp_state_t state_ff; // Master engine state.

	////////////////////////////////////////////////////////////////////
	// Decode and events.

	logic enabled, isMaster, lsb, clock_phase, wrData, wrStat, wrCtrl;
	logic cfgChange, modeFault, slaveSel, ssFall, mEdge, sEdge, edgeEv;
	logic firstOfPair, lastEdge, abortAll, slaveAbort, busy;
	logic wrAccept, wcolEv, byteDone, inBit, autoSs;
	logic [7:0] shNext;

	assign enabled = ctrl_ff[CT_EN];
	assign isMaster = ctrl_ff[CT_MASTER_SELECT];
	assign lsb = ctrl_ff[CT_LSB];
	assign clock_phase = ctrl_ff[CT_CLOCK_PHASE];
	assign wrData = wrEn && addr == ADDR_DATA;
	assign wrStat = wrEn && addr == ADDR_STATUS;
	assign wrCtrl = wrEn && addr == ADDR_CTRL;
	// A reconfiguration while running is an abort, not a retune.
	assign cfgChange = wrCtrl && enabled
		&& ((wdata ^ ctrl_ff) & CFG_MASK) != RST_BYTE;
	// The pin is a fault input only for an enabled master.
	assign modeFault = enabled && isMaster && !noFault_ff
		&& !ssIn;
	// A slave listens to its pins only while selected.
	assign slaveSel = enabled && !isMaster && !ssIn;
	assign ssFall = ssPrev_ff && !ssIn;
	assign mEdge = state_ff == SM_BUSY
		&& divCnt_ff == divLimit(ctrl_ff[CT_DIVHI:CT_DIVLO]);
	assign sEdge = slaveSel && sclkIn != sclkPrev_ff;
	assign edgeEv = isMaster ? mEdge : sEdge;
	assign firstOfPair = !edgeCnt_ff[0];
	assign lastEdge = edgeEv && edgeCnt_ff == 4'(EDGES - 1);
	assign abortAll = cfgChange || modeFault || !enabled;
	assign slaveAbort = enabled && !isMaster && ssIn
		&& edgeCnt_ff != RST_EDGE;
	// Phase zero slaves are busy from selection; phase one from clocking.
	assign busy = isMaster ? state_ff == SM_BUSY
		: (!ssIn && (!clock_phase || edgeCnt_ff != RST_EDGE));
	assign wrAccept = wrData && !done_ff && !busy;
	assign wcolEv = wrData && !done_ff && busy;
	assign byteDone = lastEdge && !abortAll;
	assign inBit = isMaster ? misoIn : mosiIn;
	// Phase one samples and shifts on the same edge.
	assign shNext = shiftIn(sh_ff, clock_phase ? inBit : rxBit_ff, lsb);
	assign autoSs = enabled && isMaster && noFault_ff
		&& ctrl_ff[CT_SELECT_OUTPUT_ENABLE];

	////////////////////////////////////////////////////////////////////
	// Control and enable registers; mode fault drops master and enable.
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_ff <= RST_BYTE;
			irqEn_ff <= 2'b00;
		end else begin
			if (wrCtrl) begin
				ctrl_ff <= wdata;
			end
			if (modeFault) begin
				ctrl_ff[CT_MASTER_SELECT] <= 1'b0;
				ctrl_ff[CT_EN] <= 1'b0;
			end
			if (wrEn && addr == ADDR_IRQEN) begin
				irqEn_ff <= wdata[IE_GLOBAL:IE_SERIAL];
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Status flags: writing zero clears, and a same-cycle set wins.
	always_ff @(posedge clk) begin
		if (rst) begin
			done_ff <= 1'b0;
			write_collision_flag_ff <= 1'b0;
			ovf_ff <= 1'b0;
			mode_fault_flag_ff <= 1'b0;
			noFault_ff <= 1'b0;
		end else begin
			if (wrStat) begin
				done_ff <= done_ff & wdata[ST_DONE];
				write_collision_flag_ff <= write_collision_flag_ff & wdata[ST_WRITE_COLLISION_FLAG];
				ovf_ff <= ovf_ff & wdata[ST_OVF];
				mode_fault_flag_ff <= mode_fault_flag_ff & wdata[ST_MODE_FAULT_FLAG];
				noFault_ff <= wdata[ST_NOFAULT];
			end
			if (byteDone) begin
				done_ff <= 1'b1;
			end
			if (byteDone && done_ff) begin
				ovf_ff <= 1'b1;
			end
			if (wcolEv) begin
				write_collision_flag_ff <= 1'b1;
			end
			if (modeFault) begin
				mode_fault_flag_ff <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Master engine state and divider.
	always_ff @(posedge clk) begin
		if (rst) begin
			state_ff <= SM_IDLE;
			divCnt_ff <= RST_DIV;
		end else begin
			case (state_ff)
				SM_IDLE: begin
					divCnt_ff <= RST_DIV;
					if (wrAccept && isMaster && enabled && !abortAll) begin
						state_ff <= SM_BUSY;
					end
				end
				SM_BUSY: begin
					divCnt_ff <= mEdge ? RST_DIV : divCnt_ff + 3'h1;
					if (abortAll || byteDone) begin
						state_ff <= SM_IDLE;
					end
				end
				default: begin
					state_ff <= SM_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Shifter and edge count, shared by master and slave.
	always_ff @(posedge clk) begin
		if (rst) begin
			sh_ff <= RST_BYTE;
			rxBit_ff <= 1'b0;
			outBit_ff <= 1'b0;
			edgeCnt_ff <= RST_EDGE;
			txFull_ff <= 1'b0;
		end else begin
			if (wrAccept) begin
				// Writes go straight into the shifter.
				sh_ff <= wdata;
				outBit_ff <= pick(wdata, lsb);
				txFull_ff <= 1'b1;
			end else if (abortAll || slaveAbort) begin
				edgeCnt_ff <= RST_EDGE;
				txFull_ff <= 1'b0;
				if (slaveAbort) begin
					sh_ff <= fillOnes(sh_ff, edgeCnt_ff[3:1], lsb);
				end
			end else if (edgeEv) begin
				edgeCnt_ff <= lastEdge ? RST_EDGE : edgeCnt_ff + 4'h1;
				if (firstOfPair) begin
					if (clock_phase) begin
						outBit_ff <= pick(sh_ff, lsb);
					end else begin
						rxBit_ff <= inBit;
					end
				end else begin
					sh_ff <= shNext;
					// Phase one must hold the line through its sampling edge.
					if (!clock_phase) begin
						outBit_ff <= pick(shNext, lsb);
					end
				end
				if (lastEdge) begin
					txFull_ff <= 1'b0;
				end
			end else if (ssFall && !isMaster && !clock_phase) begin
				// Phase zero slaves present their first bit early.
				outBit_ff <= pick(sh_ff, lsb);
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Read buffer: overrun keeps the older byte.
	always_ff @(posedge clk) begin
		if (rst) begin
			rxBuf_ff <= RST_BYTE;
		end else if (byteDone && !done_ff) begin
			rxBuf_ff <= shNext;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Pin drivers and sampled pin history.
	always_ff @(posedge clk) begin
		if (rst) begin
			sclk_ff <= 1'b0;
			sclkPrev_ff <= 1'b0;
			ssPrev_ff <= 1'b1;
			ssOut_ff <= 1'b1;
			select_output_enable_ff <= 1'b0;
			sclkOe_ff <= 1'b0;
			mosiOe_ff <= 1'b0;
			misoOe_ff <= 1'b0;
		end else begin
			sclkPrev_ff <= sclkIn;
			ssPrev_ff <= ssIn;
			if (state_ff == SM_BUSY && mEdge && !abortAll) begin
				sclk_ff <= !sclk_ff;
			end else if (state_ff != SM_BUSY) begin
				sclk_ff <= ctrl_ff[CT_CLOCK_POLARITY];
			end
			sclkOe_ff <= enabled && isMaster;
			mosiOe_ff <= enabled && isMaster;
			misoOe_ff <= slaveSel;
			// The select line follows the engine only as an output.
			select_output_enable_ff <= autoSs;
			// Select drops with the start, so a phase zero slave has its
			// first bit on the line before the first clock edge.
			ssOut_ff <= !(autoSs && (state_ff == SM_BUSY
				|| (wrAccept && isMaster && !abortAll)));
		end
	end

	////////////////////////////////////////////////////////////////////
	// Register reads and interrupt request.
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_ff <= RST_BYTE;
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= (done_ff || ovf_ff || mode_fault_flag_ff) && irqEn_ff[IE_SERIAL]
				&& irqEn_ff[IE_GLOBAL];
			rdata_ff <= RST_BYTE;
			if (rdEn) begin
				case (addr)
					ADDR_STATUS: begin
						rdata_ff <= {done_ff, write_collision_flag_ff, ovf_ff, mode_fault_flag_ff,
							noFault_ff, txFull_ff, 2'b00};
					end
					ADDR_DATA: begin
						rdata_ff <= rxBuf_ff;
					end
					ADDR_CTRL: begin
						rdata_ff <= ctrl_ff;
					end
					ADDR_IRQEN: begin
						rdata_ff <= {6'h00, irqEn_ff};
					end
					default: begin
						rdata_ff <= RST_BYTE;
					end
				endcase
			end
		end
	end

	assign rdata = rdata_ff;
	assign sclkOut = sclk_ff;
	assign sclkOe = sclkOe_ff;
	assign mosiOut = outBit_ff;
	assign mosiOe = mosiOe_ff;
	assign misoOut = outBit_ff;
	assign misoOe = misoOe_ff;
	assign ssOut = ssOut_ff;
	assign select_output_enable = select_output_enable_ff;
	assign irqReq = irq_ff;

	////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	chk_wr_blocked: assert property (
		wrData && done_ff && !txFull_ff |=> !txFull_ff)
		else $error("data write taken while done flag set");
	chk_write_collision_flag_sticky: assert property (
		(wcolEv || write_collision_flag_ff) && !(wrStat && !wdata[ST_WRITE_COLLISION_FLAG]) |=> write_collision_flag_ff)
		else $error("collision flag not set or not held");
	chk_ovf_keep: assert property (
		byteDone && done_ff |=> ovf_ff && $stable(rxBuf_ff))
		else $error("overrun not flagged or buffer lost");
	chk_mode_fault_flag_off: assert property (
		modeFault |=> mode_fault_flag_ff && !ctrl_ff[CT_EN] && !ctrl_ff[CT_MASTER_SELECT])
		else $error("mode fault not handled");
	chk_irq_req: assert property (
		(done_ff || ovf_ff || mode_fault_flag_ff) && irqEn_ff == 2'b11
		|=> irqReq)
		else $error("interrupt not requested");
	chk_done_idle: assert property (
		$rose(done_ff) && isMaster |-> state_ff == SM_IDLE)
		else $error("master still busy after byte");
	chk_slave_abort: assert property (
		slaveAbort && !wrAccept |=> edgeCnt_ff == RST_EDGE)
		else $error("slave abort did not go idle");
	chk_tx_full: assert property (
		wrAccept |=> txFull_ff)
		else $error("buffer full not shown after write");
	chk_cfg_abort: assert property (
		cfgChange |=> state_ff == SM_IDLE && edgeCnt_ff == RST_EDGE)
		else $error("reconfiguration did not abort");
	chk_master_len: assert property (
		state_ff == SM_IDLE && wrAccept && isMaster && !abortAll
		&& ctrl_ff[CT_DIVHI:CT_DIVLO] == 2'b00 && !wrCtrl
		|=> state_ff == SM_BUSY ##15 byteDone || abortAll)
		else $error("master byte length wrong");

	cov_master_byte: cover property (isMaster && byteDone);
	cov_slave_byte: cover property (!isMaster && byteDone);
	cov_overrun: cover property (byteDone && done_ff);
	cov_mode_fault: cover property (modeFault);
endmodule // smsp_core

// File: core/smsp_pkg.sv
package smsp_pkg;
	// Register offsets on the special-function register port.
	localparam logic [7:0] ADDR_STATUS = 8'hf4;
	localparam logic [7:0] ADDR_DATA = 8'hf5;
	localparam logic [7:0] ADDR_CTRL = 8'hf6;
	localparam logic [7:0] ADDR_IRQEN = 8'hf7;
	// Status register bit positions.
	localparam int ST_DONE = 7;
	localparam int ST_WRITE_COLLISION_FLAG = 6;
	localparam int ST_OVF = 5;
	localparam int ST_MODE_FAULT_FLAG = 4;
	localparam int ST_NOFAULT = 3;
	localparam int ST_TXFULL = 2;
	// Control register bit positions.
	localparam int CT_SELECT_OUTPUT_ENABLE = 7;
	localparam int CT_EN = 6;
	localparam int CT_LSB = 5;
	localparam int CT_MASTER_SELECT = 4;
	localparam int CT_CLOCK_POLARITY = 3;
	localparam int CT_CLOCK_PHASE = 2;
	localparam int CT_DIVHI = 1;
	localparam int CT_DIVLO = 0;
	// Interrupt enable register bit positions.
	localparam int IE_SERIAL = 0;
	localparam int IE_GLOBAL = 1;
	// Control bits whose change aborts a running byte.
	localparam logic [7:0] CFG_MASK = 8'h3f;
	// Reset values.
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [3:0] RST_EDGE = 4'h0;
	localparam logic [2:0] RST_DIV = 3'h0;
	// Half-period limits for dividers 2, 4, 8 and 16.
	localparam logic [2:0] HALF_DIV2 = 3'h0;
	localparam logic [2:0] HALF_DIV4 = 3'h1;
	localparam logic [2:0] HALF_DIV8 = 3'h3;
	localparam logic [2:0] HALF_DIV16 = 3'h7;
	// Master engine states.
	typedef enum logic [1:0] {
		SM_IDLE = 2'b01,
		SM_BUSY = 2'b10
	} smsp_state_t;
endpackage

// File: tb/smsp_peer.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////
// Far-side device. It acts as a slave while the core is master, and its
// master tasks clock the core when the core is slave.
module smsp_peer (
	input wire logic clk, // System clock.
	input wire logic sclk, // Clock line.
	input wire logic mosi, // Master-out line.
	input wire logic miso, // Master-in line.
	input wire logic ss, // Select line, low selects.
	input wire logic clock_polarity, // Idle clock level.
	input wire logic clock_phase, // Clock phase.
	input wire logic lsb, // Low bit first.
	input wire logic [7:0] txByte, // Byte the slave returns.
	output logic misoDrv, // Slave data drive.
	output logic [7:0] rxByte, // Byte the slave took in.
	output logic sclkDrv, // Master clock drive.
	output logic mosiDrv, // Master data drive.
	output logic ssDrv, // Master select drive.
	output logic [7:0] mRx // Byte the master took in.
);
	logic [7:0] sh; // Slave shifter.
	logic [7:0] msh; // Master shifter.
	int cnt; // Clock edges seen in this frame.
	initial begin
		misoDrv = 1'b0;
		rxByte = 8'h00;
		sclkDrv = 1'b0;
		mosiDrv = 1'b0;
		ssDrv = 1'b1;
		mRx = 8'h00;
		cnt = 0;
	end
	////////////////////////////////////////////////////////////////////////
	// Select fall opens a frame; phase 0 shows the first bit at once.
	always @(negedge ss) begin
		cnt = 0;
		sh = txByte;
		if (!clock_phase) sh_out();
	end
	// A released line holds nothing, so it shows the inverse of its bit.
	always @(posedge ss) misoDrv = ~misoDrv;
	// Phase 0 samples odd edges, phase 1 even ones.
	always @(sclk) begin
		if (!ss) begin
			cnt++;
			if (cnt[0] != clock_phase) rxByte = lsb ? {mosi, rxByte[7:1]} :
				{rxByte[6:0], mosi};
			else sh_out();
		end
	end
	task automatic sh_out;
		misoDrv = lsb ? sh[0] : sh[7];
		sh = lsb ? sh >> 1 : sh << 1;
	endtask
	////////////////////////////////////////////////////////////////////////
	// Clocks nbits bits at a half period of four clocks. Select stays low
	// through the byte; fewer than eight bits raises it mid-byte.
	task automatic master_byte(input logic [7:0] b, input int nbits);
		int e;
		msh = b;
		@(posedge clk);
		ssDrv <= 1'b0;
		sclkDrv <= clock_polarity;
		if (!clock_phase) m_out();
		for (e = 1; e <= 2 * nbits; e++) begin
			repeat (4) @(posedge clk);
			sclkDrv <= ~sclkDrv;
			if (e[0] != clock_phase) mRx <= lsb ? {miso, mRx[7:1]} :
				{mRx[6:0], miso};
			else m_out();
		end
		repeat (4) @(posedge clk);
		ssDrv <= 1'b1;
		mosiDrv <= ~mosiDrv;
		repeat (4) @(posedge clk);
	endtask
	task automatic m_out;
		mosiDrv <= lsb ? msh[0] : msh[7];
		msh = lsb ? msh >> 1 : msh << 1;
	endtask
	// Holds the select line at a level of the caller's choosing.
	task automatic select(input logic v);
		@(posedge clk);
		ssDrv <= v;
	endtask
endmodule // smsp_peer

// File: tb/smsp_core_tb.sv
`timescale 1ns/10ps
module smsp_core_tb;
	import smsp_pkg::*;
	logic clk = 1'b0; // System clock.
	logic rst = 1'b1; // Reset, held four cycles.
	logic [7:0] addr = 8'h00; // Register address.
	logic [7:0] wdata = 8'h00; // Write data.
	logic wrEn = 1'b0; // Write strobe.
	logic rdEn = 1'b0; // Read strobe.
	logic [7:0] rdata; // Read data.
	logic sclkOut, sclkOe, mosiOut, mosiOe, misoOut, misoOe; // Pin drives.
	logic ssOut, select_output_enable, irqReq; // Select drive and interrupt.
	logic peerMiso, sclkDrv, mosiDrv, ssDrv; // Far-side drives.
	logic [7:0] rxByte, mRx; // Bytes the far side took in.
	logic clock_polarity = 1'b0; // Far-side format.
	logic clock_phase = 1'b0;
	logic lsb = 1'b0;
	logic [7:0] txByte = 8'h00; // Byte the far-side slave returns.
	int failures = 0;
	int checks = 0;
	int cycles = 0;
	int n;
	int m;
	// Each line takes the level of whichever party drives it.
	wire sclkW = sclkOe ? sclkOut : sclkDrv;
	wire mosiW = mosiOe ? mosiOut : mosiDrv;
	wire misoW = misoOe ? misoOut : peerMiso;
	wire ssW = select_output_enable ? ssOut : ssDrv;
	smsp_core i_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
		.wrEn(wrEn), .rdEn(rdEn), .rdata(rdata), .sclkIn(sclkW),
		.sclkOut(sclkOut), .sclkOe(sclkOe), .mosiIn(mosiW),
		.mosiOut(mosiOut), .mosiOe(mosiOe), .misoIn(misoW),
		.misoOut(misoOut), .misoOe(misoOe), .ssIn(ssW), .ssOut(ssOut),
		.select_output_enable(select_output_enable), .irqReq(irqReq));
	smsp_peer i_peer (.clk(clk), .sclk(sclkW), .mosi(mosiW), .miso(misoW),
		.ss(ssW), .clock_polarity(clock_polarity), .clock_phase(clock_phase), .lsb(lsb), .txByte(txByte),
		.misoDrv(peerMiso), .rxByte(rxByte), .sclkDrv(sclkDrv),
		.mosiDrv(mosiDrv), .ssDrv(ssDrv), .mRx(mRx));
	always #5 clk = ~clk;
	// A hang ends the run as a mismatch.
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 10000) begin
			failures++;
			report_and_stop();
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wrEn <= 1'b1;
		@(posedge clk);
		wrEn <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe.
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rdEn <= 1'b1;
		@(posedge clk);
		rdEn <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmpBit(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chkReg(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd(a, d);
		cmp8(d, exp);
	endtask
	// Polls the status register; the bound covers the slowest divider.
	task automatic waitDone;
		logic [7:0] d;
		d = 8'h00;
		for (n = 0; n < 300 && d[ST_DONE] !== 1'b1; n++) rd(ADDR_STATUS, d);
		cmpBit(d[ST_DONE], 1'b1);
	endtask
	task automatic report_and_stop;
		if (failures == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		chkReg(ADDR_STATUS, 8'h00);
		chkReg(ADDR_DATA, 8'h00);
		chkReg(8'h10, 8'h00);
		// Ones leave the flags alone and the buffer bit is read-only.
		wr(ADDR_STATUS, 8'hfc);
		chkReg(ADDR_STATUS, 8'h08);
		// Master bytes in all four formats, one divider code each.
		for (m = 0; m < 4; m++) begin
			clock_polarity = m[1];
			clock_phase = m[0];
			lsb = m[0];
			txByte = 8'hc3 ^ 8'(m);
			wr(ADDR_CTRL, 8'h00);
			wr(ADDR_CTRL, {2'b11, lsb, 1'b1, clock_polarity, clock_phase, m[1:0]});
			// The pin drivers follow the control register one cycle late.
			repeat (2) @(negedge clk);
			cmpBit(sclkOut, clock_polarity);
			cmpBit(select_output_enable, 1'b1);
			wr(ADDR_DATA, 8'h5a + 8'(m));
			for (n = 0; n < 50 && sclkOut === clock_polarity; n++) @(negedge clk);
			cmpBit(ssOut, 1'b0);
			for (n = 0; n < 50 && sclkOut !== clock_polarity; n++) @(negedge clk);
			cmp8(8'(n), 8'(1 << m));
			waitDone();
			cmp8(rxByte, 8'h5a + 8'(m));
			chkReg(ADDR_DATA, txByte);
			cmpBit(sclkOut, clock_polarity);
			cmpBit(ssOut, 1'b1);
			wr(ADDR_STATUS, 8'h08);
		end
		// A second write mid-byte is lost; a write while done is ignored.
		wr(ADDR_DATA, 8'h3e);
		wr(ADDR_DATA, 8'h81);
		waitDone();
		cmp8(rxByte, 8'h3e);
		wr(ADDR_DATA, 8'h99);
		repeat (20) @(negedge clk);
		cmpBit(ssOut, 1'b1);
		chkReg(ADDR_STATUS, 8'hc8);
		// The request needs both enables.
		wr(ADDR_IRQEN, 8'h01);
		repeat (2) @(negedge clk);
		cmpBit(irqReq, 1'b0);
		wr(ADDR_IRQEN, 8'h03);
		repeat (2) @(negedge clk);
		cmpBit(irqReq, 1'b1);
		wr(ADDR_STATUS, 8'h08);
		repeat (2) @(negedge clk);
		cmpBit(irqReq, 1'b0);
		// Changing polarity mid-byte while enabled abandons the byte.
		wr(ADDR_DATA, 8'h42);
		repeat (30) @(negedge clk);
		wr(ADDR_CTRL, 8'hf7);
		repeat (200) @(negedge clk);
		chkReg(ADDR_STATUS, 8'h08);
		cmpBit(sclkOut, 1'b0);
		// Another party pulls select low on an enabled master.
		wr(ADDR_STATUS, 8'h00);
		wr(ADDR_CTRL, 8'h00);
		wr(ADDR_CTRL, 8'h50);
		@(negedge clk);
		cmpBit(select_output_enable, 1'b0);
		i_peer.select(1'b0);
		repeat (4) @(negedge clk);
		chkReg(ADDR_STATUS, 8'h10);
		chkReg(ADDR_CTRL, 8'h00);
		cmpBit(irqReq, 1'b1);
		i_peer.select(1'b1);
		wr(ADDR_STATUS, 8'h00);
		// Slave role, phase 0: no mode fault although detection is on.
		clock_polarity = 1'b0;
		clock_phase = 1'b0;
		lsb = 1'b0;
		wr(ADDR_CTRL, 8'h40);
		wr(ADDR_DATA, 8'h3c);
		i_peer.master_byte(8'ha5, 8);
		waitDone();
		chkReg(ADDR_DATA, 8'ha5);
		cmp8(mRx, 8'h3c);
		chkReg(ADDR_STATUS, 8'h80);
		i_peer.master_byte(8'h11, 8);
		chkReg(ADDR_STATUS, 8'ha0);
		chkReg(ADDR_DATA, 8'ha5);
		wr(ADDR_STATUS, 8'h00);
		i_peer.master_byte(8'h77, 3);
		chkReg(ADDR_STATUS, 8'h00);
		i_peer.select(1'b0);
		repeat (4) @(negedge clk);
		wr(ADDR_DATA, 8'h55);
		chkReg(ADDR_STATUS, 8'h40);
		i_peer.select(1'b1);
		// The cut byte left its three bits and then ones in the shifter.
		i_peer.master_byte(8'h00, 8);
		cmp8(mRx, 8'h7f);
		wr(ADDR_STATUS, 8'h00);
		// Phase 1 slave: first bit leaves on the first clock edge.
		wr(ADDR_CTRL, 8'h00);
		clock_phase = 1'b1;
		wr(ADDR_CTRL, 8'h44);
		wr(ADDR_DATA, 8'hb2);
		chkReg(ADDR_STATUS, 8'h04);
		i_peer.master_byte(8'h5c, 8);
		waitDone();
		chkReg(ADDR_DATA, 8'h5c);
		cmp8(mRx, 8'hb2);
		report_and_stop();
	end
endmodule // smsp_core_tb
